// [spisc_consts.vh]
`ifndef SPISC_CONSTS_VH
`define SPISC_CONSTS_VH
`define SPISC_OFF_STAT 4'h0
`define SPISC_OFF_CON2 4'h4
`define SPISC_OFF_BUF 4'h8
`define SPISC_OFF_CTRL 4'hC
`define SPISC_BIT_EN 15
`define SPISC_BIT_SIDL 13
`define SPISC_BIT_ROV 6
`define SPISC_BIT_TBF 1
`define SPISC_BIT_RBF 0
`define SPISC_BIT_FRAMED_MODE_ENABLE 15
`define SPISC_BIT_FSD 14
`define SPISC_BIT_FPOL 13
`define SPISC_BIT_FDLY 1
`define SPISC_BIT_IDLE 0
`define SPISC_BIT_MASTER 1
`define SPISC_STAT_RST 16'h0000
`define SPISC_CON2_RST 16'h0000
`define SPISC_DIV_RST 8'h04
`endif

// [spisc_sync.v]
`timescale 1ns/1ps
module spisc_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule

// [spisc_top.v]
`timescale 1ns/1ps
`include "spisc_consts.vh"
// Contract
// - enable bit turns module and pins on
// - stop-in-idle halts port in idle mode
// - overflow discards new data, sets flag
// - buffer write sets transmit full flag
// - move to shifter clears transmit full
// - receive done sets receive full flag
// - buffer read clears receive full flag
// - framed mode uses select as sync
module spisc_top #(
  parameter DW = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire serial_clock_pin_i,
  output reg serial_clock_pin_o,
  output wire serial_clock_pin_oe,
  input wire serial_data_in_pin,
  output reg serial_data_out_pin_o,
  output wire serial_data_out_pin_oe,
  input wire select_frame_pin_i,
  output reg select_frame_pin_o,
  output wire select_frame_pin_oe
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_LEAD = 4'b0010;
  localparam [3:0] S_SHIFT = 4'b0100;
  localparam [3:0] S_DONE = 4'b1000;
  localparam CW = $clog2(DW + 1);
  localparam [CW-1:0] DW_C = DW;

  reg port_enable_q, stop_in_idle_q;
  reg receive_overflow_flag_q, transmit_buffer_full_q, receive_buffer_full_q;
  reg framed_mode_enable_q, frame_pulse_direction_q;
  reg frame_pulse_polarity_q, frame_pulse_edge_select_q;
  reg idle_mode_q, master_q;
  reg [7:0] div_q;
  reg [DW-1:0] transmit_holding_register_q;
  reg [DW-1:0] receive_holding_register_q;
  reg [DW-1:0] shift_register_q;
  reg [3:0] state_q;
  reg [CW-1:0] bit_cnt_q;
  reg [7:0] div_cnt_q;
  reg ack_q;
  reg sck_prev_q, ss_prev_q;

  wire [2:0] pins_s;
  spisc_sync #(.W(3)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({serial_clock_pin_i, serial_data_in_pin, select_frame_pin_i}),
    .sync_out(pins_s)
  );
  wire sck_s = pins_s[2];
  wire sdi_s = pins_s[1];
  wire ss_s = pins_s[0];

  // single wait state gives registered read data
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  wire wr_go = avs_write & ack_q;
  wire rd_go = avs_read & ack_q;
  wire buf_wr = wr_go && (avs_address == `SPISC_OFF_BUF);
  wire buf_rd = rd_go && (avs_address == `SPISC_OFF_BUF);

  // idle stops the port only when asked to
  wire run = port_enable_q & ~(idle_mode_q & stop_in_idle_q);
  // frame pulse level follows the polarity bit
  wire ss_act = frame_pulse_polarity_q ? ss_s : ~ss_s;
  wire ss_prev_act = frame_pulse_polarity_q ? ss_prev_q : ~ss_prev_q;
  wire sck_rise_s = sck_s & ~sck_prev_q;
  wire sck_fall_s = ~sck_s & sck_prev_q;
  wire frame_slave = framed_mode_enable_q & frame_pulse_direction_q;

  // master generates its own bit clock, slave follows pin edges
  wire tick = (div_cnt_q == 8'h00);
  wire m_rise = tick & ~serial_clock_pin_o;
  wire m_fall = tick & serial_clock_pin_o;
  wire b_rise = master_q ? m_rise : sck_rise_s;
  wire b_fall = master_q ? m_fall : sck_fall_s;
  wire sel_on = framed_mode_enable_q ? 1'b0 : ~ss_s;
  wire frame_start = frame_slave & ss_act & ~ss_prev_act;
  wire load = (state_q == S_IDLE) & transmit_buffer_full_q & run &
    (master_q ? ~(framed_mode_enable_q & frame_pulse_direction_q)
      : (framed_mode_enable_q ? frame_start : sel_on));

  always @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      avs_readdata <= 32'h00000000;
      if (req & ~ack_q) begin
        // unmapped and unimplemented bits read zero
        if (avs_address == `SPISC_OFF_STAT) begin
          avs_readdata[`SPISC_BIT_EN] <= port_enable_q;
          avs_readdata[`SPISC_BIT_SIDL] <= stop_in_idle_q;
          avs_readdata[`SPISC_BIT_ROV] <= receive_overflow_flag_q;
          avs_readdata[`SPISC_BIT_TBF] <= transmit_buffer_full_q;
          avs_readdata[`SPISC_BIT_RBF] <= receive_buffer_full_q;
        end else if (avs_address == `SPISC_OFF_CON2) begin
          avs_readdata[`SPISC_BIT_FRAMED_MODE_ENABLE] <= framed_mode_enable_q;
          avs_readdata[`SPISC_BIT_FSD] <= frame_pulse_direction_q;
          avs_readdata[`SPISC_BIT_FPOL] <= frame_pulse_polarity_q;
          avs_readdata[`SPISC_BIT_FDLY] <= frame_pulse_edge_select_q;
        end else if (avs_address == `SPISC_OFF_BUF) begin
          avs_readdata[DW-1:0] <= receive_holding_register_q;
        end else if (avs_address == `SPISC_OFF_CTRL) begin
          avs_readdata[`SPISC_BIT_IDLE] <= idle_mode_q;
          avs_readdata[`SPISC_BIT_MASTER] <= master_q;
          avs_readdata[15:8] <= div_q;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      port_enable_q <= 1'b0;
      stop_in_idle_q <= 1'b0;
      framed_mode_enable_q <= 1'b0;
      frame_pulse_direction_q <= 1'b0;
      frame_pulse_polarity_q <= 1'b0;
      frame_pulse_edge_select_q <= 1'b0;
      idle_mode_q <= 1'b0;
      master_q <= 1'b0;
      div_q <= `SPISC_DIV_RST;
      transmit_holding_register_q <= {DW{1'b0}};
    end else if (wr_go) begin
      if (avs_address == `SPISC_OFF_STAT) begin
        port_enable_q <= avs_writedata[`SPISC_BIT_EN];
        stop_in_idle_q <= avs_writedata[`SPISC_BIT_SIDL];
      end else if (avs_address == `SPISC_OFF_CON2) begin
        framed_mode_enable_q <= avs_writedata[`SPISC_BIT_FRAMED_MODE_ENABLE];
        frame_pulse_direction_q <= avs_writedata[`SPISC_BIT_FSD];
        frame_pulse_polarity_q <= avs_writedata[`SPISC_BIT_FPOL];
        frame_pulse_edge_select_q <= avs_writedata[`SPISC_BIT_FDLY];
      end else if (avs_address == `SPISC_OFF_BUF) begin
        transmit_holding_register_q <= avs_writedata[DW-1:0];
      end else if (avs_address == `SPISC_OFF_CTRL) begin
        idle_mode_q <= avs_writedata[`SPISC_BIT_IDLE];
        master_q <= avs_writedata[`SPISC_BIT_MASTER];
        div_q <= avs_writedata[15:8];
      end
    end
  end

  // status flags; hardware set wins over same-cycle clear
  always @(posedge clk) begin
    if (sys_rst) begin
      receive_overflow_flag_q <= 1'b0;
      transmit_buffer_full_q <= 1'b0;
      receive_buffer_full_q <= 1'b0;
      receive_holding_register_q <= {DW{1'b0}};
    end else begin
      if (buf_wr)
        transmit_buffer_full_q <= 1'b1;
      else if (load)
        transmit_buffer_full_q <= 1'b0;
      if (state_q == S_DONE) begin
        if (receive_buffer_full_q & ~buf_rd) begin
          receive_overflow_flag_q <= 1'b1;
        end else begin
          receive_holding_register_q <= shift_register_q;
          receive_buffer_full_q <= 1'b1;
        end
      end else if (buf_rd) begin
        receive_buffer_full_q <= 1'b0;
      end
      if (wr_go && avs_address == `SPISC_OFF_STAT &&
          !avs_writedata[`SPISC_BIT_ROV] && state_q != S_DONE)
        receive_overflow_flag_q <= 1'b0;
    end
  end

  // shift engine: mode 0, msb first
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      bit_cnt_q <= {CW{1'b0}};
      shift_register_q <= {DW{1'b0}};
      div_cnt_q <= 8'h00;
      serial_clock_pin_o <= 1'b0;
      serial_data_out_pin_o <= 1'b0;
      select_frame_pin_o <= 1'b0;
      sck_prev_q <= 1'b0;
      ss_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      ss_prev_q <= ss_s;
      div_cnt_q <= (tick | state_q == S_IDLE) ? div_q : div_cnt_q - 8'h01;
      // idle level of the master pulse is the inactive level
      if (state_q == S_IDLE)
        select_frame_pin_o <= ~frame_pulse_polarity_q;
      if (~run) begin
        state_q <= S_IDLE;
        serial_clock_pin_o <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (load) begin
              shift_register_q <= transmit_holding_register_q;
              serial_data_out_pin_o <= transmit_holding_register_q[DW-1];
              bit_cnt_q <= DW_C;
              // master drives the pulse; edge select sets its place
              if (master_q & framed_mode_enable_q) begin
                select_frame_pin_o <= frame_pulse_polarity_q;
                state_q <= frame_pulse_edge_select_q ? S_SHIFT : S_LEAD;
              end else begin
                state_q <= S_SHIFT;
              end
            end
          end
          S_LEAD: begin
            if (tick) begin
              select_frame_pin_o <= ~frame_pulse_polarity_q;
              state_q <= S_SHIFT;
            end
          end
          S_SHIFT: begin
            if (master_q & tick)
              serial_clock_pin_o <= ~serial_clock_pin_o;
            if (b_rise) begin
              shift_register_q <= {shift_register_q[DW-2:0], sdi_s};
              bit_cnt_q <= bit_cnt_q - {{(CW-1){1'b0}}, 1'b1};
              if (master_q & framed_mode_enable_q)
                select_frame_pin_o <= ~frame_pulse_polarity_q;
            end
            if (b_fall) begin
              serial_data_out_pin_o <= shift_register_q[DW-1];
              if (bit_cnt_q == {CW{1'b0}})
                state_q <= S_DONE;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // pins belong to the port only while enabled
  assign serial_clock_pin_oe = run & master_q;
  assign serial_data_out_pin_oe = run & (master_q | sel_on | framed_mode_enable_q);
  assign select_frame_pin_oe = run & framed_mode_enable_q &
    ~frame_pulse_direction_q;
endmodule

// [spisc_slave_model.sv]
`timescale 1ns/1ps
module spisc_slave_model (
  input wire sclk,
  input wire sclk_oe,
  input wire mosi,
  output wire miso,
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte
);
  reg [2:0] cnt_q = 3'h0;
  reg last_q = 1'b0;
  // msb first, mode 0: capture on rise, advance on fall
  always @(posedge sclk) if (sclk_oe) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sclk) if (sclk_oe) begin
    last_q <= miso;
    cnt_q <= cnt_q + 3'h1;
  end
  // released line shows the inverse so a stale bit cannot pass
  assign miso = sclk_oe ? tx_byte[3'h7 - cnt_q] : ~last_q;
endmodule

// [spisc_properties.sv]
`timescale 1ns/1ps
module spisc_properties #(
  parameter DW = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire serial_clock_pin_oe,
  input wire serial_data_out_pin_oe,
  input wire select_frame_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire wr_ok = avs_write && !avs_waitrequest;
  wire rd_ok = avs_read && !avs_waitrequest;
  wire req = avs_read || avs_write;
  reg en_q, mst_q, frm_q, fsd_q;
  // shadow of config bits as software wrote them
  always @(posedge clk) begin
    if (sys_rst) begin
      {en_q, mst_q, frm_q, fsd_q} <= 4'h0;
    end else begin
      if (wr_ok && avs_address == 4'h0) en_q <= avs_writedata[15];
      if (wr_ok && avs_address == 4'hC) mst_q <= avs_writedata[1];
      if (wr_ok && avs_address == 4'h4)
        {frm_q, fsd_q} <= avs_writedata[15:14];
    end
  end
  chk_wait_one: assert property ($rose(req) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait state not one");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_unmapped_zero: assert property (
    rd_ok && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_stat_spare: assert property (
    rd_ok && avs_address == 4'h0 |-> (avs_readdata & ~32'h0000A043) == 0)
    else $error("status spare bits set");
  chk_frame_spare: assert property (
    rd_ok && avs_address == 4'h4 |-> (avs_readdata & ~32'h0000E002) == 0)
    else $error("framing spare bits set");
  chk_rdata_hold: assert property (!req && !$past(req) |->
    $stable(avs_readdata)) else $error("read data moved while idle");
  chk_pins_off: assert property (!en_q && !$past(en_q) |->
    !(serial_clock_pin_oe || serial_data_out_pin_oe || select_frame_pin_oe))
    else $error("pins driven while disabled");
  chk_clock_master: assert property (
    serial_clock_pin_oe |-> en_q && mst_q) else $error("clock driven badly");
  chk_frame_drive: assert property (
    select_frame_pin_oe |-> en_q && frm_q && !fsd_q)
    else $error("frame pulse driven badly");
  cover property (serial_clock_pin_oe);
  cover property (select_frame_pin_oe);
  cover property (rd_ok && avs_address == 4'h2);
endmodule
bind spisc_top spisc_properties #(.DW(DW)) u_chk (.clk(clk),
  .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_data_out_pin_oe(serial_data_out_pin_oe),
  .select_frame_pin_oe(select_frame_pin_oe));

// [spisc_top_tb_top.sv]
`timescale 1ns/1ps
module spisc_top_tb_top;
  reg clk, sys_rst, avs_read, avs_write;
  reg [3:0] avs_address;
  reg [31:0] avs_writedata, rq;
  reg [7:0] s_tx;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, sck, sck_oe, sdo, sdo_oe, sel, sel_oe, miso;
  wire [7:0] s_rx;
  reg [7:0] fp_len, fp_gap;
  reg fp_done;
  integer bad_count, n_checks, i, k;
  integer cyc = 0;
  // slave pins held idle: only master operation is exercised here
  spisc_top #(.DW(8)) dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .serial_clock_pin_i(1'b0),
    .serial_clock_pin_o(sck), .serial_clock_pin_oe(sck_oe),
    .serial_data_in_pin(miso), .serial_data_out_pin_o(sdo),
    .serial_data_out_pin_oe(sdo_oe), .select_frame_pin_i(1'b1),
    .select_frame_pin_o(sel), .select_frame_pin_oe(sel_oe));
  spisc_slave_model peer (.sclk(sck), .sclk_oe(sck_oe), .mosi(sdo),
    .miso(miso), .tx_byte(s_tx), .rx_byte(s_rx));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task wrap_up;
    begin
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  // frame pulse length and its lead before the first bit clock rise
  always @(posedge clk) begin
    if (avs_write && avs_address == 4'h8) begin
      fp_len <= 8'h00;
      fp_gap <= 8'h00;
      fp_done <= 1'b0;
    end else if (sel_oe && !fp_done) begin
      if (sel === (k == 0))
        fp_len <= fp_len + 8'h01;
      else if (sck)
        fp_done <= 1'b1;
      else if (fp_len != 8'h00)
        fp_gap <= fp_gap + 8'h01;
    end
  end
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task ac(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    ac(1'b1, a, d);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      ac(1'b0, a, 32'h0);
      chk($sformatf("reg_%h", a), rq, e);
    end
  endtask
  // status polled over the bus, bounded
  task poll(input integer b);
    begin
      i = 0;
      rq = 32'h0;
      while (rq[b] !== 1'b1 && i < 100) begin
        ac(1'b0, 4'h0, 32'h0);
        i = i + 1;
      end
      chk("status_poll", rq[b], 1);
    end
  endtask
  initial begin
    bad_count = 0;
    n_checks = 0;
    sys_rst = 1;
    avs_read = 0;
    avs_write = 0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    s_tx = 8'h3C;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0);
    rd(4'h4, 32'h0);
    rd(4'h2, 32'h0);
    wr(4'h4, 32'hFFFF);
    rd(4'h4, 32'hE002);
    wr(4'h4, 32'h0);
    wr(4'h0, 32'hFFFF);
    rd(4'h0, 32'hA000);
    wr(4'h0, 32'h0);
    wr(4'hC, 32'h0302);
    wr(4'h8, 32'hA5);
    rd(4'h0, 32'h0002);
    wr(4'h0, 32'h8000);
    poll(0);
    rd(4'h0, 32'h8001);
    chk("peer_rx", s_rx, 32'hA5);
    rd(4'h8, 32'h3C);
    rd(4'h0, 32'h8000);
    s_tx <= 8'h96;
    wr(4'h8, 32'h11);
    poll(0);
    s_tx <= 8'h69;
    wr(4'h8, 32'h22);
    poll(6);
    rd(4'h0, 32'h8041);
    rd(4'h8, 32'h96);
    wr(4'h0, 32'h8000);
    rd(4'h0, 32'h8000);
    wr(4'hC, 32'h0303);
    wr(4'h0, 32'hA000);
    wr(4'h8, 32'h77);
    repeat (100) @(posedge clk);
    rd(4'h0, 32'hA002);
    wr(4'h0, 32'h8000);
    poll(0);
    rd(4'h8, 32'h69);
    wr(4'hC, 32'h0302);
    for (k = 0; k < 2; k = k + 1) begin
      wr(4'h4, k ? 32'h8002 : 32'hA000);
      rd(4'h4, k ? 32'h8002 : 32'hA000);
      wr(4'h8, 32'h5A ^ k);
      poll(0);
      chk("peer_rx", s_rx, 32'h5A ^ k);
      chk("frame_len", fp_len, 32'h4);
      chk("frame_gap", fp_gap, k ? 32'h0 : 32'h4);
      rd(4'h8, 32'h69);
    end
    wrap_up;
  end
endmodule
